/* File: shared/drc_pkg.sv */
/*
 * Constants and types shared by the dual rheostat code control block.
 * Assumes one 200 MHz clock; all widths are fixed.
 */
package drc_pkg;

	// ------------------------------------------------------------
	// code and channel geometry
	// ------------------------------------------------------------
	localparam int            CHANNELS  = 2;
	localparam int            CODE_W    = 10;
	localparam int            PAT_W     = 8;
	localparam int            PAD_W     = CODE_W - PAT_W;
	localparam logic [CODE_W-1:0] CODE_MAX  = 10'h3FF;
	localparam logic [CODE_W-1:0] CODE_MIN  = 10'h000;
	localparam logic [CODE_W-1:0] CODE_ONE  = 10'h001;
	// highest resistance until the first load
	localparam logic [CODE_W-1:0] CODE_RESET = CODE_MAX;
	localparam logic [CODE_W-1:0] SETPOINT_RESET = 10'h000;
	localparam logic [PAD_W-1:0]  PAD_ZERO  = 2'h0;

	// ------------------------------------------------------------
	// tolerance word
	// ------------------------------------------------------------
	localparam int            TOL_W        = 16;
	localparam int            TOL_SIGN_BIT = 15;
	localparam int            TOL_MAG_W    = 15;
	localparam logic [TOL_W-1:0] TOL_RESET = 16'h0000;
	// non-volatile locations of the two tolerance words
	localparam logic [7:0]    NVM_TOL_FIRST = 8'h95;
	localparam logic [7:0]    NVM_TOL_LAST  = 8'h98;

	// ------------------------------------------------------------
	// field values of the mode bits
	// ------------------------------------------------------------
	localparam logic POL_DEFAULT    = 1'h0;
	localparam logic MAP_FROM_MSB   = 1'h0;
	localparam logic MODE_POT       = 1'h1;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLOCK_MHZ           = 200;
	localparam int COUNT_CLOCK_MAX_MHZ = 25;
	// matrix inputs are synchronised, each edge costs this many cycles
	localparam int SYNC_STAGES         = 2;

	// ------------------------------------------------------------
	// power-on sequence
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_WAIT = 3'h1,
		ST_LOAD = 3'h2,
		ST_RUN  = 3'h4
	} drc_init_t;

endpackage : drc_pkg

/* File: rtl/drc_channel.sv */
/*
 * One rheostat code counter with saturation and a limit flag.
 * Assumes all event inputs are one-cycle pulses on the same clock.
 */
`timescale 1ns/1ps

module drc_channel (
	input  wire logic                      clock,
	input  wire logic                      nrst,
	input  wire logic                      initLoad,
	input  wire logic [drc_pkg::CODE_W-1:0] initCode,
	input  wire logic                      reloadHit,
	input  wire logic                      patternSel,
	input  wire logic [drc_pkg::CODE_W-1:0] patternCode,
	input  wire logic                      updateHit,
	input  wire logic [drc_pkg::CODE_W-1:0] updateCode,
	input  wire logic                      stepHit,
	input  wire logic                      stepUp,
	input  wire logic                      forceOn,
	input  wire logic [drc_pkg::CODE_W-1:0] forceCode,
	output logic      [drc_pkg::CODE_W-1:0] code,
	output logic                           limit
);

	// ------------------------------------------------------------
	// next code, priority order
	// ------------------------------------------------------------
	logic [drc_pkg::CODE_W-1:0] next_code;

	always_comb begin
		next_code = code;
		if (initLoad) begin
			next_code = initCode;
		end else if (forceOn) begin
			next_code = forceCode;
		end else if (updateHit) begin
			// bus write wins over a coinciding reload
			next_code = updateCode;
		end else if (reloadHit) begin
			if (patternSel) begin
				next_code = patternCode;
			end else begin
				next_code = initCode;
			end
		end else if (stepHit) begin
			// stepping also runs in pattern mode
			if (stepUp && code != drc_pkg::CODE_MAX) begin
				next_code = code + drc_pkg::CODE_ONE;
			end else if (!stepUp && code != drc_pkg::CODE_MIN) begin
				next_code = code - drc_pkg::CODE_ONE;
			end
		end
	end

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			code <= drc_pkg::CODE_RESET;
		end else begin
			code <= next_code;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			limit <= 1'b1;
		end else begin
			limit <= (next_code == drc_pkg::CODE_MAX) ||
				(next_code == drc_pkg::CODE_MIN);
		end
	end

endmodule : drc_channel

/* File: rtl/drc_top.sv */
/*
 * Dual rheostat code control: two saturating 10-bit code counters,
 * setpoint, readback and tolerance registers, potentiometer mode,
 * pattern reload and power-on loading.
 * Assumes: counting clocks, directions and reload lines come from the
 * routing matrix asynchronously; the serial-bus slave, the non-volatile
 * loader and the pattern generator run on this clock.
 */
// Contract
// - each rheostat has a 10-bit code, 1024 positions, resistance rises with code
// - power-on copies stored initial code into setpoint and counter
// - live counter value is shown in a read-only readback register
// - terminals stay disconnected until power-on loading is finished
// - a bus write to a setpoint replaces the counter value
// - count clock rising edge steps up on direction high, down on low
// - polarity bit one inverts the meaning of the direction input
// - reload rising edge restores stored code into setpoint and counter
// - with pattern drive the reload edge loads pattern data instead
// - counter saturates at 0x3FF going up and 0x00 going down
// - limit flag is high while the code is at maximum or minimum
// - potentiometer mode forces second code to inverse of first setpoint
// - alignment bit places the 8-bit pattern word high or low
// - tolerance word: bit 15 sign, 15-bit magnitude, from nvm
// - host may read and write the rheostat registers unless protected
// - a setpoint write reaches the counter at the bus stop condition
// - pattern path acts only while its enable bit is one
// - clocked counting still works while pattern drive is on
`timescale 1ns/1ps

module drc_top (
	input  wire logic                          clock,
	input  wire logic                          nrst,
	// non-volatile loader
	input  wire logic                          nvmReady,
	input  wire logic [drc_pkg::CODE_W-1:0]    nvmInitCode0,
	input  wire logic [drc_pkg::CODE_W-1:0]    nvmInitCode1,
	input  wire logic [drc_pkg::TOL_W-1:0]     nvmTolerance0,
	input  wire logic [drc_pkg::TOL_W-1:0]     nvmTolerance1,
	// serial-bus register writes
	input  wire logic                          setpointWrite0,
	input  wire logic                          setpointWrite1,
	input  wire logic [drc_pkg::CODE_W-1:0]    setpointWdata,
	input  wire logic                          toleranceWrite0,
	input  wire logic                          toleranceWrite1,
	input  wire logic [drc_pkg::TOL_W-1:0]     toleranceWdata,
	input  wire logic                          busStop,
	input  wire logic                          writeProtect,
	// configuration bits
	input  wire logic                          directionPolarity0,
	input  wire logic                          directionPolarity1,
	input  wire logic                          pairPotentiometerSelect,
	input  wire logic                          patternWordAlignment,
	input  wire logic                          rheostatEnable0,
	input  wire logic                          rheostatEnable1,
	input  wire logic                          patternPathEnable0,
	input  wire logic                          patternPathEnable1,
	// pattern generator
	input  wire logic [drc_pkg::PAT_W-1:0]     patternData,
	// routing matrix
	input  wire logic                          countClock0,
	input  wire logic                          countClock1,
	input  wire logic                          countDirection0,
	input  wire logic                          countDirection1,
	input  wire logic                          restorePulse0,
	input  wire logic                          restorePulse1,
	// results
	output logic      [drc_pkg::CODE_W-1:0]    codeSetpoint0,
	output logic      [drc_pkg::CODE_W-1:0]    codeSetpoint1,
	output logic      [drc_pkg::CODE_W-1:0]    codeReadback0,
	output logic      [drc_pkg::CODE_W-1:0]    codeReadback1,
	output logic      [drc_pkg::TOL_MAG_W-1:0] toleranceMagnitude0,
	output logic      [drc_pkg::TOL_MAG_W-1:0] toleranceMagnitude1,
	output logic                               toleranceSign0,
	output logic                               toleranceSign1,
	output logic                               firstLimitFlag,
	output logic                               secondLimitFlag,
	output logic                               terminalConnect0,
	output logic                               terminalConnect1,
	output logic                               initDone
);

	localparam int N = drc_pkg::CHANNELS;
	localparam int W = drc_pkg::CODE_W;

	// ------------------------------------------------------------
	// per-channel views of the ports
	// ------------------------------------------------------------
	logic [N-1:0]              rawClock;
	logic [N-1:0]              rawDir;
	logic [N-1:0]              rawRestore;
	logic [N-1:0]              polarity;
	logic [N-1:0]              enable;
	logic [N-1:0]              patternSel;
	logic [N-1:0]              spWrite;
	logic [N-1:0]              tolWrite;
	logic [W-1:0]              initCode   [N];
	logic [drc_pkg::TOL_W-1:0] nvmTol     [N];

	assign rawClock   = {countClock1, countClock0};
	assign rawDir     = {countDirection1, countDirection0};
	assign rawRestore = {restorePulse1, restorePulse0};
	assign polarity   = {directionPolarity1, directionPolarity0};
	assign enable     = {rheostatEnable1, rheostatEnable0};
	assign patternSel = {patternPathEnable1, patternPathEnable0};
	assign spWrite    = {setpointWrite1, setpointWrite0};
	assign tolWrite   = {toleranceWrite1, toleranceWrite0};
	assign initCode[0] = nvmInitCode0;
	assign initCode[1] = nvmInitCode1;
	assign nvmTol[0]   = nvmTolerance0;
	assign nvmTol[1]   = nvmTolerance1;

	// ------------------------------------------------------------
	// power-on sequence
	// ------------------------------------------------------------
	drc_pkg::drc_init_t state;
	drc_pkg::drc_init_t next_state;
	logic               initLoad;
	logic               running;

	always_comb begin
		next_state = state;
		unique case (state)
			drc_pkg::ST_WAIT: begin
				if (nvmReady) begin
					next_state = drc_pkg::ST_LOAD;
				end
			end
			drc_pkg::ST_LOAD: begin
				next_state = drc_pkg::ST_RUN;
			end
			drc_pkg::ST_RUN: begin
				next_state = drc_pkg::ST_RUN;
			end
			default: begin
				next_state = drc_pkg::ST_WAIT;
			end
		endcase
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state <= drc_pkg::ST_WAIT;
		end else begin
			state <= next_state;
		end
	end

	assign initLoad = (state == drc_pkg::ST_LOAD);
	assign running  = (state == drc_pkg::ST_RUN);

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			initDone <= 1'b0;
		end else begin
			initDone <= (next_state == drc_pkg::ST_RUN);
		end
	end

	// ------------------------------------------------------------
	// matrix input synchronisers and edge detection
	// ------------------------------------------------------------
	// the matrix counting clock is sampled, not used as a clock, so its
	// rate is bounded by the sampling; direction must be stable about
	// two cycles around each counting edge
	logic [3*N-1:0] syncIn;
	logic [3*N-1:0] syncA;
	logic [3*N-1:0] syncB;
	logic [3*N-1:0] syncC;
	logic [N-1:0]   clockRise;
	logic [N-1:0]   restoreRise;
	logic [N-1:0]   dirLevel;

	assign syncIn = {rawRestore, rawDir, rawClock};

	genvar s;
	generate
		for (s = 0; s < 3 * N; s++) begin : g_sync
			always_ff @(posedge clock or negedge nrst) begin
				if (!nrst) begin
					syncA[s] <= 1'b0;
					syncB[s] <= 1'b0;
					syncC[s] <= 1'b0;
				end else begin
					syncA[s] <= syncIn[s];
					syncB[s] <= syncA[s];
					syncC[s] <= syncB[s];
				end
			end
		end
	endgenerate

	assign clockRise   = syncB[N-1:0] & ~syncC[N-1:0];
	assign dirLevel    = syncB[2*N-1:N];
	assign restoreRise = syncB[3*N-1:2*N] & ~syncC[3*N-1:2*N];

	// ------------------------------------------------------------
	// pattern word mapping
	// ------------------------------------------------------------
	logic [W-1:0] patternCode;

	always_comb begin
		if (patternWordAlignment == drc_pkg::MAP_FROM_MSB) begin
			patternCode = {patternData, drc_pkg::PAD_ZERO};
		end else begin
			patternCode = {drc_pkg::PAD_ZERO, patternData};
		end
	end

	// ------------------------------------------------------------
	// channels
	// ------------------------------------------------------------
	logic [W-1:0]              setpoint      [N];
	logic [W-1:0]              next_setpoint [N];
	logic [W-1:0]              code          [N];
	logic [drc_pkg::TOL_W-1:0] tolerance     [N];
	logic [N-1:0]              pending;
	logic [N-1:0]              limit;
	logic [N-1:0]              connect;
	logic [N-1:0]              wrOk;
	logic [N-1:0]              reloadHit;
	logic [N-1:0]              updateHit;
	logic [N-1:0]              stepHit;
	logic [N-1:0]              stepUp;
	logic                      potMode;

	assign potMode = (pairPotentiometerSelect == drc_pkg::MODE_POT);

	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_ch
			logic forceOn;

			// second setpoint is locked to the inverse of the first in pot mode
			assign forceOn = potMode && (i == 1) && running;
			assign wrOk[i] = spWrite[i] && running && !writeProtect &&
				!forceOn;
			assign reloadHit[i] = restoreRise[i] && running;
			assign updateHit[i] = busStop && (pending[i] || wrOk[i]) &&
				running;
			// count step is dropped when a load of any kind lands
			assign stepHit[i] = clockRise[i] && running &&
				!reloadHit[i] && !updateHit[i];
			assign stepUp[i] = (polarity[i] == drc_pkg::POL_DEFAULT) ?
				dirLevel[i] : !dirLevel[i];

			always_comb begin
				next_setpoint[i] = setpoint[i];
				if (initLoad) begin
					next_setpoint[i] = initCode[i];
				end else if (forceOn) begin
					next_setpoint[i] = ~next_setpoint[0];
				end else if (wrOk[i]) begin
					next_setpoint[i] = setpointWdata;
				end else if (reloadHit[i] && !patternSel[i]) begin
					next_setpoint[i] = initCode[i];
				end
			end

			always_ff @(posedge clock or negedge nrst) begin
				if (!nrst) begin
					setpoint[i] <= drc_pkg::SETPOINT_RESET;
				end else begin
					setpoint[i] <= next_setpoint[i];
				end
			end

			// a write waits for the stop; a new write in the stop cycle
			// is applied at once, so clearing then loses nothing
			always_ff @(posedge clock or negedge nrst) begin
				if (!nrst) begin
					pending[i] <= 1'b0;
				end else if (busStop || !running) begin
					pending[i] <= 1'b0;
				end else if (wrOk[i]) begin
					pending[i] <= 1'b1;
				end
			end

			always_ff @(posedge clock or negedge nrst) begin
				if (!nrst) begin
					tolerance[i] <= drc_pkg::TOL_RESET;
				end else if (initLoad) begin
					tolerance[i] <= nvmTol[i];
				end else if (tolWrite[i] && running && !writeProtect) begin
					tolerance[i] <= toleranceWdata;
				end
			end

			always_ff @(posedge clock or negedge nrst) begin
				if (!nrst) begin
					connect[i] <= 1'b0;
				end else begin
					connect[i] <= (next_state == drc_pkg::ST_RUN) &&
						enable[i];
				end
			end

			drc_channel u_channel (
				.clock       (clock),
				.nrst        (nrst),
				.initLoad    (initLoad),
				.initCode    (initCode[i]),
				.reloadHit   (reloadHit[i]),
				.patternSel  (patternSel[i]),
				.patternCode (patternCode),
				.updateHit   (updateHit[i]),
				.updateCode  (next_setpoint[i]),
				.stepHit     (stepHit[i]),
				.stepUp      (stepUp[i]),
				.forceOn     (forceOn),
				.forceCode   (~next_setpoint[0]),
				.code        (code[i]),
				.limit       (limit[i])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign codeSetpoint0       = setpoint[0];
	assign codeSetpoint1       = setpoint[1];
	assign codeReadback0       = code[0];
	assign codeReadback1       = code[1];
	assign toleranceSign0      = tolerance[0][drc_pkg::TOL_SIGN_BIT];
	assign toleranceSign1      = tolerance[1][drc_pkg::TOL_SIGN_BIT];
	assign toleranceMagnitude0 = tolerance[0][drc_pkg::TOL_MAG_W-1:0];
	assign toleranceMagnitude1 = tolerance[1][drc_pkg::TOL_MAG_W-1:0];
	assign firstLimitFlag      = limit[0];
	assign secondLimitFlag     = limit[1];
	assign terminalConnect0    = connect[0];
	assign terminalConnect1    = connect[1];

endmodule : drc_top

/* File: tb/drc_top_assertions.sv */
/*
 * Port checker for drc_top, bound at the foot of this file.
 * Assumes one clock and the active-low asynchronous reset nrst.
 */
`timescale 1ns/1ps

module drc_top_assertions (
	input wire logic        clock,
	input wire logic        nrst,
	input wire logic        setpointWrite0,
	input wire logic [9:0]  setpointWdata,
	input wire logic        toleranceWrite0,
	input wire logic [15:0] toleranceWdata,
	input wire logic        busStop,
	input wire logic        writeProtect,
	input wire logic        directionPolarity0,
	input wire logic        pairPotentiometerSelect,
	input wire logic        countClock0,
	input wire logic        countDirection0,
	input wire logic [9:0]  codeSetpoint0,
	input wire logic [9:0]  codeSetpoint1,
	input wire logic [9:0]  codeReadback0,
	input wire logic [9:0]  codeReadback1,
	input wire logic [14:0] toleranceMagnitude0,
	input wire logic        toleranceSign0,
	input wire logic        firstLimitFlag,
	input wire logic        secondLimitFlag,
	input wire logic        terminalConnect0,
	input wire logic        terminalConnect1,
	input wire logic        initDone
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);
	wire atEnd0 = codeReadback0 == 10'h3FF || codeReadback0 == 10'h000;
	wire atEnd1 = codeReadback1 == 10'h3FF || codeReadback1 == 10'h000;
	wire take0  = setpointWrite0 && !writeProtect && initDone;
	limit_first_a: assert property (
		firstLimitFlag == atEnd0) else $error("first limit flag wrong");
	limit_second_a: assert property (
		secondLimitFlag == atEnd1) else $error("second limit flag wrong");
	terminal_open_a: assert property (
		!initDone |-> !terminalConnect0 && !terminalConnect1)
		else $error("terminal closed before loading");
	pot_inverse_a: assert property (
		pairPotentiometerSelect && $past(pairPotentiometerSelect) && initDone
		&& $past(initDone) |-> codeSetpoint1 == ~codeSetpoint0)
		else $error("second setpoint not inverse of first");
	setpoint_take_a: assert property (
		take0 |=> codeSetpoint0 == $past(setpointWdata))
		else $error("setpoint write not taken");
	stop_update_a: assert property (
		take0 && busStop |=> codeReadback0 == $past(setpointWdata))
		else $error("counter not loaded at stop");
	tolerance_hold_a: assert property (
		toleranceWrite0 && writeProtect && initDone
		|=> $stable(toleranceSign0) && $stable(toleranceMagnitude0))
		else $error("protected tolerance write changed register");
	step_up_a: assert property (
		$rose(countClock0) && countDirection0 && !directionPolarity0 && initDone
		|-> ##4 codeReadback0 == (($past(codeReadback0, 4) == 10'h3FF) ?
		10'h3FF : $past(codeReadback0, 4) + 10'h001))
		else $error("count up step wrong");
endmodule : drc_top_assertions

bind drc_top drc_top_assertions chk (.clock, .nrst, .setpointWrite0,
	.setpointWdata, .toleranceWrite0, .toleranceWdata, .busStop,
	.writeProtect, .directionPolarity0, .pairPotentiometerSelect,
	.countClock0, .countDirection0, .codeSetpoint0, .codeSetpoint1,
	.codeReadback0, .codeReadback1, .toleranceMagnitude0, .toleranceSign0,
	.firstLimitFlag, .secondLimitFlag, .terminalConnect0, .terminalConnect1,
	.initDone);

/* File: tb/drc_matrix_model.sv */
/*
 * Routing matrix model: counting clocks, directions and restore pulses.
 * Assumes pulse is called just after a rising edge of clock.
 */
`timescale 1ns/1ps

module drc_matrix_model (
	input  wire logic clock,
	output logic      countClock0,
	output logic      countClock1,
	output logic      countDirection0,
	output logic      countDirection1,
	output logic      restorePulse0,
	output logic      restorePulse1
);
	initial begin
		{countClock0, countClock1, restorePulse0, restorePulse1} = 4'h0;
		{countDirection0, countDirection1} = 2'h0;
	end
	// only source of counting clocks; four high, four low keeps 25 MHz
	task automatic pulse(input int ch, input logic dir, input logic cnt,
		input logic rel);
		if (ch == 0) begin
			{countDirection0, countClock0, restorePulse0} = {dir, cnt, rel};
		end else begin
			{countDirection1, countClock1, restorePulse1} = {dir, cnt, rel};
		end
		repeat (4) @(posedge clock);
		#1;
		// direction flips once the clock is low, never reused
		if (ch == 0) begin
			{countDirection0, countClock0, restorePulse0} = {~dir, 2'h0};
		end else begin
			{countDirection1, countClock1, restorePulse1} = {~dir, 2'h0};
		end
		repeat (4) @(posedge clock);
		#1;
	endtask : pulse
endmodule : drc_matrix_model

/* File: tb/tb.sv */
/*
 * Self-checking bench for drc_top with a reference model of both codes.
 * Assumes drc_matrix_model drives the matrix lines.
 */
`timescale 1ns/1ps

module tb;
	logic        clock = 1'b0;
	logic        nrst, nvmReady, busStop, writeProtect;
	logic        setpointWrite0, setpointWrite1, toleranceWrite0;
	logic        toleranceWrite1, directionPolarity0, directionPolarity1;
	logic        pairPotentiometerSelect, patternWordAlignment;
	logic        rheostatEnable0, rheostatEnable1;
	logic        patternPathEnable0, patternPathEnable1;
	logic        countClock0, countClock1, countDirection0, countDirection1;
	logic        restorePulse0, restorePulse1, toleranceSign0, toleranceSign1;
	logic        firstLimitFlag, secondLimitFlag, initDone;
	logic        terminalConnect0, terminalConnect1;
	logic [7:0]  patternData;
	logic [9:0]  nvmInitCode0, nvmInitCode1, setpointWdata, d;
	logic [9:0]  codeSetpoint0, codeSetpoint1, codeReadback0, codeReadback1;
	logic [14:0] toleranceMagnitude0, toleranceMagnitude1;
	logic [15:0] nvmTolerance0, nvmTolerance1, toleranceWdata;
	logic [9:0]  mc [2], ms [2];
	logic [15:0] te [2];
	int          pend [2] = '{0, 0};
	int          errors = 0, compares = 0;
	always #2.5 clock = ~clock;
	drc_top dut (.clock, .nrst, .nvmReady, .nvmInitCode0, .nvmInitCode1,
		.nvmTolerance0, .nvmTolerance1, .setpointWrite0, .setpointWrite1,
		.setpointWdata, .toleranceWrite0, .toleranceWrite1, .toleranceWdata,
		.busStop, .writeProtect, .directionPolarity0, .directionPolarity1,
		.pairPotentiometerSelect, .patternWordAlignment, .rheostatEnable0,
		.rheostatEnable1, .patternPathEnable0, .patternPathEnable1,
		.patternData, .countClock0, .countClock1, .countDirection0,
		.countDirection1, .restorePulse0, .restorePulse1, .codeSetpoint0,
		.codeSetpoint1, .codeReadback0, .codeReadback1, .toleranceMagnitude0,
		.toleranceMagnitude1, .toleranceSign0, .toleranceSign1,
		.firstLimitFlag, .secondLimitFlag, .terminalConnect0,
		.terminalConnect1, .initDone);
	drc_matrix_model mx (.clock, .countClock0, .countClock1, .countDirection0,
		.countDirection1, .restorePulse0, .restorePulse1);
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : cyc
	task automatic check_code(input logic [9:0] got, input logic [9:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t code %h expected %h", $time, got, exp);
		end
	endtask : check_code
	task automatic check_bit(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t flag %b expected %b", $time, got, exp);
		end
	endtask : check_bit
	task automatic check_tol(input logic gs, input logic [14:0] gm,
		input logic [15:0] exp);
		compares++;
		if ({gs, gm} !== exp) begin
			errors++;
			$display("[FAIL] %0t tolerance %h expected %h", $time, {gs, gm}, exp);
		end
	endtask : check_tol
	task automatic check_all;
		check_code(codeReadback0, mc[0]);
		check_code(codeReadback1, mc[1]);
		check_code(codeSetpoint0, ms[0]);
		check_code(codeSetpoint1, ms[1]);
		check_bit(firstLimitFlag, mc[0] inside {10'h3FF, 10'h000});
		check_bit(secondLimitFlag, mc[1] inside {10'h3FF, 10'h000});
		check_bit(initDone, 1'b1);
	endtask : check_all
	task automatic follow_pot;
		if (pairPotentiometerSelect) begin
			ms[1] = ~ms[0];
			mc[1] = ~ms[0];
		end
	endtask : follow_pot
	task automatic bus(input int ch, input logic [9:0] v, input logic wr,
		input logic stop);
		setpointWdata = v;
		busStop = stop;
		setpointWrite0 = wr && ch == 0;
		setpointWrite1 = wr && ch == 1;
		cyc(1);
		{setpointWrite0, setpointWrite1, busStop} = 3'h0;
		if (wr && !writeProtect && !(ch == 1 && pairPotentiometerSelect)) begin
			ms[ch] = v;
			pend[ch] = 1;
		end
		for (int i = 0; i < 2; i++) begin
			if (stop && pend[i] == 1) mc[i] = ms[i];
			if (stop) pend[i] = 0;
		end
		follow_pot();
		cyc(1);
	endtask : bus
	task automatic tol(input int ch, input logic [15:0] v);
		toleranceWdata = v;
		toleranceWrite0 = ch == 0;
		toleranceWrite1 = ch == 1;
		cyc(1);
		{toleranceWrite0, toleranceWrite1} = 2'h0;
		if (!writeProtect) te[ch] = v;
		cyc(1);
	endtask : tol
	task automatic step(input int ch, input logic dir);
		logic up;
		up = dir ^ (ch == 0 ? directionPolarity0 : directionPolarity1);
		mx.pulse(ch, dir, 1'b1, 1'b0);
		if (up && mc[ch] != 10'h3FF) mc[ch] = mc[ch] + 10'h001;
		if (!up && mc[ch] != 10'h000) mc[ch] = mc[ch] - 10'h001;
	endtask : step
	task automatic reload(input int ch);
		logic [9:0] nv;
		nv = ch == 0 ? nvmInitCode0 : nvmInitCode1;
		mx.pulse(ch, 1'b0, 1'b0, 1'b1);
		if (!(ch == 0 ? patternPathEnable0 : patternPathEnable1)) begin
			ms[ch] = nv;
			mc[ch] = nv;
		end else if (patternWordAlignment) mc[ch] = {2'h0, patternData};
		else mc[ch] = {patternData, 2'h0};
	endtask : reload
	task automatic print_verdict;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : print_verdict
	// the whole sequence needs well under a thousand cycles
	initial begin
		#(20000 * 5);
		errors++;
		print_verdict();
	end
	initial begin
		{nrst, nvmReady, busStop, writeProtect, setpointWrite0, setpointWrite1,
			toleranceWrite0, toleranceWrite1, directionPolarity0,
			directionPolarity1, pairPotentiometerSelect, patternWordAlignment,
			rheostatEnable1, patternPathEnable0, patternPathEnable1} = '0;
		rheostatEnable0 = 1'b1;
		{patternData, setpointWdata, toleranceWdata} = '0;
		void'($urandom(32'hb88d_7813));
		nvmInitCode0 = 10'($urandom);
		nvmInitCode1 = 10'($urandom);
		nvmTolerance0 = 16'($urandom);
		nvmTolerance1 = 16'($urandom);
		repeat (8) @(posedge clock);
		#1;
		nrst = 1'b1;
		cyc(2);
		check_bit(terminalConnect0, 1'b0);
		check_bit(initDone, 1'b0);
		check_code(codeReadback0, 10'h3FF);
		nvmReady = 1'b1;
		cyc(4);
		{mc[0], ms[0], mc[1], ms[1]} = {{2{nvmInitCode0}}, {2{nvmInitCode1}}};
		{te[0], te[1]} = {nvmTolerance0, nvmTolerance1};
		check_all();
		check_bit(terminalConnect0, 1'b1);
		check_tol(toleranceSign1, toleranceMagnitude1, te[1]);
		rheostatEnable1 = 1'b1;
		d = 10'($urandom);
		bus(0, d, 1'b1, 1'b0);
		check_all();
		check_bit(terminalConnect1, 1'b1);
		bus(0, 10'h000, 1'b0, 1'b1);
		check_all();
		writeProtect = 1'b1;
		bus(1, ~ms[1], 1'b1, 1'b1);
		tol(0, 16'($urandom));
		writeProtect = 1'b0;
		check_all();
		check_tol(toleranceSign0, toleranceMagnitude0, te[0]);
		tol(1, 16'($urandom));
		check_tol(toleranceSign1, toleranceMagnitude1, te[1]);
		for (int p = 0; p < 4; p++) begin
			{directionPolarity0, directionPolarity1} = {2{p[1]}};
			step(0, p[0]);
			step(1, p[0]);
			check_all();
		end
		{directionPolarity0, directionPolarity1} = 2'h0;
		bus(0, 10'h3FF, 1'b1, 1'b0);
		bus(1, 10'h000, 1'b1, 1'b1);
		step(0, 1'b1);
		step(1, 1'b0);
		check_all();
		step(0, 1'b0);
		check_all();
		for (int i = 0; i < 8; i++) begin
			{patternPathEnable0, patternPathEnable1} = {2{i[1]}};
			patternWordAlignment = i[2];
			patternData = 8'($urandom);
			reload(i % 2);
			check_all();
		end
		step(1, 1'b1);
		check_all();
		{patternPathEnable0, patternPathEnable1} = 2'h0;
		d = 10'($urandom);
		// write and stop sampled at the edge where reload and step land
		fork
			mx.pulse(0, 1'b0, 1'b1, 1'b1);
			begin
				cyc(2);
				bus(0, d, 1'b1, 1'b1);
			end
		join
		check_all();
		pairPotentiometerSelect = 1'b1;
		cyc(2);
		follow_pot();
		check_all();
		bus(0, 10'($urandom), 1'b1, 1'b1);
		bus(1, 10'($urandom), 1'b1, 1'b1);
		check_all();
		print_verdict();
	end
endmodule : tb
